// *** logic/pwc_top.sv ***
// periodic wakeup counter with axi4-lite register slave
`timescale 1ns/100ps
module pwc_top
  import pwc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic low_power_osc_1khz,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic debug_halt,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  // source clock synchronisers
  logic [2:0] src_in;
  logic [2:0] rise;
  assign src_in = {internal_ref_clock, external_ref_clock, low_power_osc_1khz};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [SYNC_STAGES-1:0] sync_q;
      logic acc_q;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sync_q <= '0;
          acc_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[SYNC_STAGES-2:0], src_in[g]};
          if (sync_q[1] == sync_q[2]) begin
            acc_q <= sync_q[2];
          end
        end
      end
      assign rise[g] = (sync_q[1] == sync_q[2]) && sync_q[2] && !acc_q;
    end
  endgenerate

  // registers
  pwc_sc_type sc_q;
  logic [7:0] limit_q;
  logic [7:0] count_q;
  logic [PRE_W-1:0] pre_q;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] mask_q;
  logic dbg_q;

  // write channel
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic aw_full_d;
  logic w_full_d;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign aw_full_d = wr_go ? 1'b0 : (aw_full_q || aw_take);
  assign w_full_d = wr_go ? 1'b0 : (w_full_q || w_take);

  logic wr_sc;
  logic wr_limit;
  logic wr_evt;
  logic wr_mask;
  logic wr_hit;
  logic [7:0] wbyte;
  pwc_sc_type wsc;
  assign wbyte = w_data_q[7:0];
  assign wsc = pwc_sc_type'(wbyte);
  assign wr_sc = wr_go && w_strb_q[0] && aw_addr_q == OFS_STATUS_CONTROL;
  assign wr_limit = wr_go && w_strb_q[0] && aw_addr_q == OFS_MATCH_LIMIT;
  assign wr_evt = wr_go && w_strb_q[0] && aw_addr_q == OFS_EVT_STATUS;
  assign wr_mask = wr_go && w_strb_q[0] && aw_addr_q == OFS_EVT_MASK;
  assign wr_hit = aw_addr_q == OFS_STATUS_CONTROL || aw_addr_q == OFS_TICK_COUNT
    || aw_addr_q == OFS_MATCH_LIMIT || aw_addr_q == OFS_EVT_STATUS
    || aw_addr_q == OFS_EVT_MASK;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= !aw_full_d;
      s_axi_wready <= !w_full_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // division ratio for one divider code; zero stops the counter
  function automatic logic [PRE_W-1:0] pwc_ratio(input logic src_lo, input logic [3:0] code);
    logic [PRE_W-1:0] r;
    r = '0;
    if (!src_lo) begin
      unique case (code)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'ha: r = 18'h00004;
        4'hb: r = 18'h0000a;
        4'hc: r = 18'h00010;
        4'hd: r = 18'h00064;
        4'he: r = 18'h001f4;
        4'hf: r = 18'h003e8;
      endcase
    end else begin
      unique case (code)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003e8;
        4'h9: r = 18'h007d0;
        4'ha: r = 18'h01388;
        4'hb: r = 18'h02710;
        4'hc: r = 18'h04e20;
        4'hd: r = 18'h0c350;
        4'he: r = 18'h186a0;
        4'hf: r = 18'h30d40;
      endcase
    end
    return r;
  endfunction : pwc_ratio

  // counting path
  logic sel_rise;
  logic cfg_change;
  logic restart;
  logic [PRE_W-1:0] ratio;
  logic pre_tick;
  logic at_limit;
  logic match_evt;
  logic suspend_evt;
  assign sel_rise = sc_q.source_select[1] ? rise[2] :
    (sc_q.source_select[0] ? rise[1] : rise[0]);
  assign ratio = pwc_ratio(sc_q.source_select[0], sc_q.divider_select);
  assign cfg_change = wr_sc && ((wsc.source_select != sc_q.source_select)
    || (wsc.divider_select != sc_q.divider_select));
  assign restart = cfg_change || wr_limit;
  assign pre_tick = sel_rise && !debug_halt && ratio != '0
    && pre_q == ratio - 18'h00001;
  assign at_limit = count_q == limit_q;
  assign match_evt = pre_tick && at_limit && !restart;
  assign suspend_evt = debug_halt && !dbg_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      count_q <= '0;
      dbg_q <= 1'b0;
    end else begin
      dbg_q <= debug_halt;
      if (restart) begin
        pre_q <= '0;
        count_q <= '0;
      end else if (sel_rise && !debug_halt && ratio != '0) begin
        pre_q <= pre_tick ? '0 : pre_q + 18'h00001;
        if (pre_tick) begin
          count_q <= at_limit ? 8'h00 : count_q + 8'h01;
        end
      end
    end
  end

  // control, limit and event registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sc_q <= pwc_sc_type'(SC_RESET);
      limit_q <= LIMIT_RESET;
      evt_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr_sc) begin
        sc_q.source_select <= wsc.source_select;
        sc_q.match_irq_enable <= wsc.match_irq_enable;
        sc_q.divider_select <= wsc.divider_select;
      end
      sc_q.match_flag <= match_evt || (sc_q.match_flag && !(wr_sc && wsc.match_flag));
      if (wr_limit) begin
        limit_q <= wbyte;
      end
      evt_q[EVT_MATCH] <= match_evt
        || (evt_q[EVT_MATCH] && !(wr_evt && wbyte[EVT_MATCH]));
      evt_q[EVT_SUSPEND] <= suspend_evt
        || (evt_q[EVT_SUSPEND] && !(wr_evt && wbyte[EVT_SUSPEND]));
      if (wr_mask) begin
        mask_q <= wbyte[EVT_W-1:0];
      end
    end
  end

  // interrupt output
  logic irq_d;
  assign irq_d = (sc_q.match_flag && sc_q.match_irq_enable) || (|(evt_q & mask_q));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // read channel
  logic ar_take;
  logic [7:0] rd_byte;
  logic rd_hit;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = s_axi_araddr == OFS_STATUS_CONTROL || s_axi_araddr == OFS_TICK_COUNT
    || s_axi_araddr == OFS_MATCH_LIMIT || s_axi_araddr == OFS_EVT_STATUS
    || s_axi_araddr == OFS_EVT_MASK;
  assign rd_byte = (s_axi_araddr == OFS_STATUS_CONTROL) ? sc_q :
    (s_axi_araddr == OFS_TICK_COUNT) ? count_q :
    (s_axi_araddr == OFS_MATCH_LIMIT) ? limit_q :
    (s_axi_araddr == OFS_EVT_STATUS) ? {6'h00, evt_q} :
    (s_axi_araddr == OFS_EVT_MASK) ? {6'h00, mask_q} : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : pwc_top

// *** logic/pwc_pkg.sv ***
// shared constants and types for the periodic wakeup counter
package pwc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TICK_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MATCH_LIMIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h10;
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned SRC_LO = 5;
  localparam int unsigned IE_BIT = 4;
  localparam int unsigned DIV_LO = 0;
  localparam int unsigned EVT_MATCH = 0;
  localparam int unsigned EVT_SUSPEND = 1;
  localparam int unsigned EVT_W = 2;
  localparam int unsigned PRE_W = 18;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SRC_LPO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;

  typedef struct packed {
    logic match_flag;
    logic [1:0] source_select;
    logic match_irq_enable;
    logic [3:0] divider_select;
  } pwc_sc_type;

  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] div;
  } pwc_cfg_type;
endpackage : pwc_pkg

// *** verif/pwc_sva.sv ***
// bus and reset checker for the wakeup counter
`timescale 1ns/100ps
module pwc_sva
  import pwc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_byte_only: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  chk_reset_clear: assert property ($fell(rst)
    |-> !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs live after reset");
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : pwc_sva

bind pwc_top pwc_sva u_pwc_sva (.*);

// *** verif/pwc_tb.sv ***
// self-checking bench for the wakeup counter
`timescale 1ns/100ps
module testbench
  import pwc_pkg::*;
;
  logic ref_clk, rst, low_power_osc_1khz, external_ref_clock, internal_ref_clock, debug_halt;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  int error_cnt, comparisons;
  pwc_top u_pwc_top (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic summarize;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic stall(input int n);
    if (n == 60) begin
      error_cnt++;
      $display("unexpected at %0t: no answer", $time);
      summarize();
    end
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    stall(n);
    s_axi_bready <= 1'b0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    stall(n);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata, {24'h000000, ex});
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge ref_clk);
  endtask : rd
  task automatic edges(input int k, input logic [2:0] m);
    repeat (k) begin
      @(posedge ref_clk);
      {internal_ref_clock, external_ref_clock, low_power_osc_1khz} <= m;
      repeat (4) @(posedge ref_clk);
      {internal_ref_clock, external_ref_clock, low_power_osc_1khz} <= 3'h0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask : edges
  task automatic ck_irq(input logic e);
    repeat (2) @(posedge ref_clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask : ck_irq
  task automatic t_regs;
    rd(8'h00, 8'h00, RESP_OKAY);
    rd(8'h08, 8'h00, RESP_OKAY);
    wr(8'h04, 8'h55, RESP_OKAY);
    rd(8'h04, 8'h00, RESP_OKAY);
    wr(8'h14, 8'h01, RESP_SLVERR);
    rd(8'h14, 8'h00, RESP_SLVERR);
  endtask : t_regs
  task automatic t_match;
    wr(8'h08, 8'h02, RESP_OKAY);
    wr(8'h00, 8'h08, RESP_OKAY);
    edges(2, 3'h1);
    edges(1, 3'h2);
    rd(8'h04, 8'h02, RESP_OKAY);
    edges(1, 3'h1);
    rd(8'h04, 8'h00, RESP_OKAY);
    rd(8'h00, 8'h88, RESP_OKAY);
    ck_irq(1'b0);
    wr(8'h00, 8'h98, RESP_OKAY);
    rd(8'h00, 8'h18, RESP_OKAY);
    edges(3, 3'h1);
    ck_irq(1'b1);
    wr(8'h00, 8'h18, RESP_OKAY);
    rd(8'h00, 8'h98, RESP_OKAY);
    wr(8'h00, 8'h98, RESP_OKAY);
    ck_irq(1'b0);
  endtask : t_match
  task automatic t_divide;
    edges(1, 3'h1);
    wr(8'h00, 8'h19, RESP_OKAY);
    rd(8'h04, 8'h00, RESP_OKAY);
    edges(7, 3'h1);
    rd(8'h04, 8'h00, RESP_OKAY);
    edges(1, 3'h1);
    rd(8'h04, 8'h01, RESP_OKAY);
    wr(8'h00, 8'h59, RESP_OKAY);
    rd(8'h04, 8'h00, RESP_OKAY);
    wr(8'h00, 8'h40, RESP_OKAY);
    edges(2, 3'h4);
    rd(8'h04, 8'h00, RESP_OKAY);
    wr(8'h00, 8'h48, RESP_OKAY);
    edges(1, 3'h4);
    rd(8'h04, 8'h01, RESP_OKAY);
  endtask : t_divide
  task automatic t_halt;
    debug_halt <= 1'b1;
    edges(2, 3'h4);
    rd(8'h04, 8'h01, RESP_OKAY);
    debug_halt <= 1'b0;
    edges(1, 3'h4);
    rd(8'h04, 8'h02, RESP_OKAY);
    wr(8'h08, 8'h00, RESP_OKAY);
    rd(8'h04, 8'h00, RESP_OKAY);
    wr(8'h00, 8'hc8, RESP_OKAY);
    rd(8'h00, 8'h48, RESP_OKAY);
    edges(1, 3'h4);
    rd(8'h00, 8'hc8, RESP_OKAY);
  endtask : t_halt
  task automatic t_events;
    ck_irq(1'b0);
    rd(8'h0c, 8'h03, RESP_OKAY);
    wr(8'h10, 8'h01, RESP_OKAY);
    ck_irq(1'b1);
    wr(8'h0c, 8'h03, RESP_OKAY);
    ck_irq(1'b0);
    rd(8'h0c, 8'h00, RESP_OKAY);
  endtask : t_events
  initial begin
    rst = 1'b1;
    {low_power_osc_1khz, external_ref_clock, internal_ref_clock, debug_halt} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    ck_irq(1'b0);
    t_regs();
    t_match();
    t_divide();
    t_halt();
    t_events();
    summarize();
  end
endmodule : testbench
